/* File: tcra_core.sv */
// tiny cpu core: reset flow, sleep and background entry, operand addressing
`timescale 1ns/1ps
`default_nettype none
module tcra_core (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // reset and debug pins
    input wire logic ext_reset_n_in,
    input wire logic low_voltage_in,
    input wire logic debug_entry_pin_in,
    // same-clock system events
    input wire logic watchdog_timer_timeout_in,
    input wire logic illegal_addr_in,
    input wire logic wake_irq_in,
    input wire logic bkg_go_in,
    // program and data memory
    output logic [13:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    input wire logic [7:0] mem_rdata_in,
    // status
    output logic cpu_clk_en_out,
    output logic stop_mode_out,
    output logic bkg_active_out,
    output var tcra_pkg::tcra_cause_t reset_cause_out,
    output var tcra_pkg::tcra_pc_t pc_out,
    output var tcra_pkg::tcra_flags_t flags_out,
    output logic [7:0] acc_out,
    output logic [7:0] index_pointer_out
);
    tcra_pkg::tcra_state_t state_q, state_d;
    tcra_pkg::tcra_pc_t pc_q, pc_d;
    tcra_pkg::tcra_pc_t spc_q, spc_d;
    tcra_pkg::tcra_pc_t pc_inc;
    tcra_pkg::tcra_flags_t flags_q, flags_d;
    tcra_pkg::tcra_mem_req_t req_q, req_d;
    tcra_pkg::tcra_fctl_t z_ctl, c_ctl;
    tcra_pkg::tcra_amode_t ag_mode;
    logic [7:0] acc_q, acc_d;
    logic [7:0] x_q, x_d;
    logic [7:0] opc_q, opc_d;
    logic [7:0] hi_q, hi_d;
    logic [8:0] res9;
    logic idx_sel_q, idx_sel_d;
    logic stop_q, stop_d;
    logic core_reset;
    logic release_pulse;
    logic debug_entry;
    logic bad_opcode;
    logic [7:0] rd_byte;
    logic [13:0] ag_addr;
    logic [13:0] ag_raw;
    logic ag_idx;

    function automatic logic [13:0] branch_target(input logic [13:0] pc, input logic [7:0] off);
        branch_target = pc + {{6{off[7]}}, off};
    endfunction : branch_target

    function automatic logic flag_upd(input tcra_pkg::tcra_fctl_t ctl, input logic old, input logic res);
        unique case (ctl)
            tcra_pkg::FLAG_KEEP: flag_upd = old;
            tcra_pkg::FLAG_CLR: flag_upd = 1'b0;
            tcra_pkg::FLAG_SET: flag_upd = 1'b1;
            tcra_pkg::FLAG_RES: flag_upd = res;
        endcase
    endfunction : flag_upd

    tcra_reset_ctl u_reset_ctl (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .ext_reset_n_in(ext_reset_n_in),
        .low_voltage_in(low_voltage_in),
        .debug_entry_pin_in(debug_entry_pin_in),
        .watchdog_in(watchdog_timer_timeout_in),
        .bad_opcode_in(bad_opcode),
        .bad_addr_in(illegal_addr_in),
        .core_reset_out(core_reset),
        .release_out(release_pulse),
        .debug_entry_out(debug_entry),
        .cause_out(reset_cause_out)
    );

    // decode of the byte just read
    logic is_tiny_add, is_lda_srt, is_sta_srt, is_two_byte, is_sleep_op;
    assign rd_byte = idx_sel_q ? x_q : mem_rdata_in;
    assign is_tiny_add = (rd_byte[7:4] == tcra_pkg::OP_ADD_TNY_HI);
    assign is_lda_srt = (rd_byte[7:5] == tcra_pkg::OP_LDA_SRT_HI);
    assign is_sta_srt = (rd_byte[7:5] == tcra_pkg::OP_STA_SRT_HI);
    assign is_sleep_op = (rd_byte == tcra_pkg::OP_WAIT) || (rd_byte == tcra_pkg::OP_STOP);
    assign is_two_byte = (rd_byte == tcra_pkg::OP_ADD_IMM) || (rd_byte == tcra_pkg::OP_ADD_DIR) ||
                         (rd_byte == tcra_pkg::OP_BCC) || (rd_byte == tcra_pkg::OP_JMP_EXT) ||
                         (rd_byte == tcra_pkg::OP_JSR_EXT);
    assign pc_inc = tcra_pkg::tcra_pc_t'(pc_q + 14'h0001);

    // operand field source depends on which byte is in flight
    assign ag_mode = (state_q == tcra_pkg::S_DECODE) ?
                     (is_tiny_add ? tcra_pkg::ADDR_TINY : tcra_pkg::ADDR_SHORT) :
                     (state_q == tcra_pkg::S_OPER) ? tcra_pkg::ADDR_DIRECT : tcra_pkg::ADDR_FULL;

    tcra_addr_gen u_addr_gen (
        .mode_in(ag_mode),
        .field_in(rd_byte),
        .ext_high_in(hi_q),
        .index_in(x_q),
        .raw_addr_out(ag_raw),
        .addr_out(ag_addr),
        .idx_ptr_sel_out(ag_idx)
    );

    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        spc_d = spc_q;
        acc_d = acc_q;
        x_d = x_q;
        opc_d = opc_q;
        hi_d = hi_q;
        stop_d = stop_q;
        idx_sel_d = 1'b0;
        req_d = '0;
        z_ctl = tcra_pkg::FLAG_KEEP;
        c_ctl = tcra_pkg::FLAG_KEEP;
        res9 = 9'h000;
        bad_opcode = 1'b0;
        unique case (state_q)
            tcra_pkg::S_FETCH: begin
                if (release_pulse && debug_entry) begin
                    state_d = tcra_pkg::S_BKG;
                end else begin
                    req_d.addr = pc_q;
                    req_d.rd = 1'b1;
                    pc_d = pc_inc;
                    state_d = tcra_pkg::S_DECODE;
                end
            end
            tcra_pkg::S_DECODE: begin
                opc_d = rd_byte;
                state_d = tcra_pkg::S_FETCH;
                if (rd_byte == tcra_pkg::OP_SHL) begin
                    // one code serves both shift-left spellings
                    res9 = {acc_q, 1'b0};
                    acc_d = res9[7:0];
                    z_ctl = tcra_pkg::FLAG_RES;
                    c_ctl = tcra_pkg::FLAG_RES;
                end else if (rd_byte == tcra_pkg::OP_NOP) begin
                    state_d = tcra_pkg::S_FETCH;
                end else if (is_sleep_op) begin
                    stop_d = (rd_byte == tcra_pkg::OP_STOP);
                    state_d = tcra_pkg::S_SLEEP;
                end else if (rd_byte == tcra_pkg::OP_BGND) begin
                    state_d = tcra_pkg::S_BKG;
                end else if (rd_byte == tcra_pkg::OP_RTS) begin
                    pc_d = spc_q;
                end else if (is_tiny_add || is_lda_srt) begin
                    req_d.addr = ag_addr;
                    req_d.rd = !ag_idx;
                    idx_sel_d = ag_idx;
                    state_d = tcra_pkg::S_DATA;
                end else if (is_sta_srt) begin
                    req_d.addr = ag_addr;
                    req_d.wdata = acc_q;
                    req_d.wr = !ag_idx;
                    if (ag_idx) begin
                        x_d = acc_q;
                    end
                end else if (is_two_byte) begin
                    req_d.addr = pc_q;
                    req_d.rd = 1'b1;
                    pc_d = pc_inc;
                    state_d = tcra_pkg::S_OPER;
                end else begin
                    bad_opcode = 1'b1;
                end
            end
            tcra_pkg::S_OPER: begin
                hi_d = rd_byte;
                state_d = tcra_pkg::S_FETCH;
                if (opc_q == tcra_pkg::OP_ADD_IMM) begin
                    res9 = {1'b0, acc_q} + {1'b0, rd_byte};
                    acc_d = res9[7:0];
                    z_ctl = tcra_pkg::FLAG_RES;
                    c_ctl = tcra_pkg::FLAG_RES;
                end else if (opc_q == tcra_pkg::OP_ADD_DIR) begin
                    req_d.addr = ag_addr;
                    req_d.rd = !ag_idx;
                    idx_sel_d = ag_idx;
                    state_d = tcra_pkg::S_DATA;
                end else if (opc_q == tcra_pkg::OP_BCC) begin
                    // pc already points past the offset byte
                    if (!flags_q.carry) begin
                        pc_d = tcra_pkg::tcra_pc_t'(branch_target(pc_q, rd_byte));
                    end
                end else begin
                    req_d.addr = pc_q;
                    req_d.rd = 1'b1;
                    pc_d = pc_inc;
                    state_d = tcra_pkg::S_OPER2;
                end
            end
            tcra_pkg::S_OPER2: begin
                pc_d = tcra_pkg::tcra_pc_t'(ag_raw);
                if (opc_q == tcra_pkg::OP_JSR_EXT) begin
                    spc_d = pc_q;
                end
                state_d = tcra_pkg::S_FETCH;
            end
            tcra_pkg::S_DATA: begin
                state_d = tcra_pkg::S_FETCH;
                z_ctl = tcra_pkg::FLAG_RES;
                if (opc_q[7:4] == tcra_pkg::OP_ADD_TNY_HI || opc_q == tcra_pkg::OP_ADD_DIR) begin
                    res9 = {1'b0, acc_q} + {1'b0, rd_byte};
                    c_ctl = tcra_pkg::FLAG_RES;
                end else begin
                    res9 = {1'b0, rd_byte};
                end
                acc_d = res9[7:0];
            end
            tcra_pkg::S_SLEEP: begin
                // wake only; pc already holds the next instruction
                if (wake_irq_in) begin
                    stop_d = 1'b0;
                    state_d = tcra_pkg::S_FETCH;
                end
            end
            tcra_pkg::S_BKG: begin
                if (bkg_go_in) begin
                    state_d = tcra_pkg::S_FETCH;
                end
            end
            default: state_d = tcra_pkg::S_FETCH;
        endcase
        flags_d.zero = flag_upd(z_ctl, flags_q.zero, res9[7:0] == 8'h00);
        flags_d.carry = flag_upd(c_ctl, flags_q.carry, res9[8]);
    end

    // sequencing registers: a reset drops whatever was in flight
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= tcra_pkg::S_FETCH;
            pc_q <= tcra_pkg::RESET_VECTOR;
            req_q <= '0;
            idx_sel_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (core_reset) begin
            state_q <= tcra_pkg::S_FETCH;
            pc_q <= tcra_pkg::RESET_VECTOR;
            req_q <= '0;
            idx_sel_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            req_q <= req_d;
            idx_sel_q <= idx_sel_d;
            stop_q <= stop_d;
        end
    end

    // working registers keep their contents across a core reset; only arst_n_in clears them
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            spc_q <= '0;
            acc_q <= 8'h00;
            x_q <= 8'h00;
            opc_q <= 8'h00;
            hi_q <= 8'h00;
            flags_q <= '0;
        end else if (!core_reset) begin
            spc_q <= spc_d;
            acc_q <= acc_d;
            x_q <= x_d;
            opc_q <= opc_d;
            hi_q <= hi_d;
            flags_q <= flags_d;
        end
    end

    assign mem_addr_out = req_q.addr;
    assign mem_wdata_out = req_q.wdata;
    assign mem_rd_out = req_q.rd;
    assign mem_wr_out = req_q.wr;
    // gated during the reset hold and during wait or stop
    assign cpu_clk_en_out = !core_reset && (state_q != tcra_pkg::S_SLEEP);
    assign stop_mode_out = stop_q;
    assign bkg_active_out = (state_q == tcra_pkg::S_BKG);
    assign pc_out = pc_q;
    assign flags_out = flags_q;
    assign acc_out = acc_q;
    assign index_pointer_out = x_q;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    a_fetch_vector: assert property (release_pulse && !debug_entry |=>
        mem_rd_out && mem_addr_out == tcra_pkg::RESET_VECTOR)
        else $error("first fetch not at reset vector");
    a_abort_inflight: assert property (core_reset |=> !mem_rd_out && !mem_wr_out)
        else $error("access survived reset");
    a_cause_record: assert property (bad_opcode && !core_reset |-> ##2 reset_cause_out.bad_opcode)
        else $error("illegal opcode cause not recorded");
    a_clock_hold: assert property (core_reset |-> !cpu_clk_en_out)
        else $error("cpu clock ran during reset");
    a_bkg_entry: assert property (release_pulse && debug_entry |=>
        bkg_active_out && !mem_rd_out)
        else $error("debug strap did not enter background");
    a_bkg_idle: assert property (bkg_active_out && !bkg_go_in && !core_reset |=>
        bkg_active_out && !mem_rd_out && !mem_wr_out)
        else $error("background mode not idle");
    a_sleep_gate: assert property (state_q == tcra_pkg::S_SLEEP && !wake_irq_in && !core_reset |=>
        state_q == tcra_pkg::S_SLEEP && !cpu_clk_en_out)
        else $error("sleep left without wake");
    a_wake_resume: assert property (state_q == tcra_pkg::S_SLEEP && wake_irq_in && !core_reset |=>
        state_q == tcra_pkg::S_FETCH ##1 mem_rd_out && mem_addr_out == $past(pc_q, 2))
        else $error("wake did not resume at next instruction");
    a_irq_no_divert: assert property (state_q == tcra_pkg::S_FETCH && wake_irq_in && !core_reset
        && !release_pulse |=> mem_addr_out == $past(pc_q))
        else $error("interrupt diverted the fetch");
    a_shift_equal: assert property (state_q == tcra_pkg::S_DECODE && rd_byte == tcra_pkg::OP_SHL
        && !core_reset |=> acc_q == {$past(acc_q[6:0]), 1'b0} && flags_q.carry == $past(acc_q[7]))
        else $error("shift left result wrong");
    a_branch_target: assert property (state_q == tcra_pkg::S_OPER && opc_q == tcra_pkg::OP_BCC
        && !flags_q.carry && !core_reset |=> pc_q == branch_target($past(pc_q), $past(rd_byte)))
        else $error("branch target wrong");
    a_idx_redirect: assert property (ag_raw == tcra_pkg::IDX_DATA_ADDR |-> ag_addr == {6'h00, x_q})
        else $error("pointer window not redirected");
    a_tiny_range: assert property (state_q == tcra_pkg::S_DECODE && is_tiny_add |->
        ag_raw[13:4] == 10'h000 && ag_raw[3:0] == rd_byte[3:0])
        else $error("tiny address out of range");
    a_direct_page: assert property (state_q == tcra_pkg::S_OPER |-> ag_raw == {6'h00, rd_byte})
        else $error("direct address outside page zero");

    c_wake: cover property (state_q == tcra_pkg::S_SLEEP ##1 state_q == tcra_pkg::S_FETCH);
    c_bkg: cover property (release_pulse && debug_entry ##1 bkg_active_out);
    c_branch: cover property (state_q == tcra_pkg::S_OPER && opc_q == tcra_pkg::OP_BCC && !flags_q.carry);
    c_window: cover property (ag_raw == tcra_pkg::IDX_DATA_ADDR && (req_d.rd || req_d.wr));
endmodule : tcra_core
`default_nettype wire

/* File: tcra_pkg.sv */
// shared constants and types of the tiny cpu control and addressing core
package tcra_pkg;
    // address space and pointer window
    localparam int PC_HIGH_W = 6;
    localparam int PC_LOW_W = 8;
    localparam int ADDR_W = PC_HIGH_W + PC_LOW_W;
    localparam logic [13:0] RESET_VECTOR = 14'h3FFD;
    localparam logic [13:0] IDX_DATA_ADDR = 14'h000E;
    localparam logic [13:0] IDX_PTR_ADDR = 14'h000F;

    // opcodes
    localparam logic [7:0] OP_SHL = 8'h48;
    localparam logic [7:0] OP_BCC = 8'h34;
    localparam logic [7:0] OP_ADD_IMM = 8'hAB;
    localparam logic [7:0] OP_ADD_DIR = 8'hBB;
    localparam logic [7:0] OP_JMP_EXT = 8'hBC;
    localparam logic [7:0] OP_JSR_EXT = 8'hBD;
    localparam logic [7:0] OP_RTS = 8'hBE;
    localparam logic [7:0] OP_BGND = 8'hBF;
    localparam logic [7:0] OP_WAIT = 8'hAF;
    localparam logic [7:0] OP_STOP = 8'hAE;
    localparam logic [7:0] OP_NOP = 8'hAC;
    localparam logic [3:0] OP_ADD_TNY_HI = 4'h6;
    localparam logic [2:0] OP_LDA_SRT_HI = 3'h6;
    localparam logic [2:0] OP_STA_SRT_HI = 3'h7;

    typedef enum logic [1:0] {ADDR_TINY, ADDR_SHORT, ADDR_DIRECT, ADDR_FULL} tcra_amode_t;
    typedef enum logic [1:0] {FLAG_KEEP, FLAG_CLR, FLAG_SET, FLAG_RES} tcra_fctl_t;
    typedef enum logic [6:0] {
        S_FETCH = 7'h01, S_DECODE = 7'h02, S_OPER = 7'h04, S_OPER2 = 7'h08,
        S_DATA = 7'h10, S_SLEEP = 7'h20, S_BKG = 7'h40
    } tcra_state_t;
    typedef enum logic [2:0] {RS_RECORD = 3'h1, RS_HOLD = 3'h2, RS_RUN = 3'h4} tcra_rstate_t;

    typedef struct packed {logic zero; logic carry;} tcra_flags_t;
    typedef struct packed {logic [5:0] high; logic [7:0] low;} tcra_pc_t;
    typedef struct packed {
        logic power_on;
        logic ext_pin;
        logic low_volt;
        logic watchdog;
        logic bad_opcode;
        logic bad_addr;
    } tcra_cause_t;
    typedef struct packed {logic [13:0] addr; logic [7:0] wdata; logic rd; logic wr;} tcra_mem_req_t;
endpackage : tcra_pkg

/* File: tcra_addr_gen.sv */
// operand address formation: tiny, short, direct and full fields plus pointer window
`timescale 1ns/1ps
`default_nettype none
module tcra_addr_gen (
    // operand fields
    input wire tcra_pkg::tcra_amode_t mode_in,
    input wire logic [7:0] field_in,
    input wire logic [7:0] ext_high_in,
    input wire logic [7:0] index_in,
    // result
    output logic [13:0] raw_addr_out,
    output logic [13:0] addr_out,
    output logic idx_ptr_sel_out
);
    logic [13:0] tiny_addr;
    logic [13:0] short_addr;
    logic [13:0] direct_addr;
    logic [13:0] full_addr;

    assign tiny_addr = {10'h000, field_in[3:0]};
    assign short_addr = {9'h000, field_in[4:0]};
    assign direct_addr = {6'h00, field_in};
    // top two bits of the high byte are dropped in a 16 kbyte space
    assign full_addr = {ext_high_in[5:0], field_in};
    assign raw_addr_out = (mode_in == tcra_pkg::ADDR_TINY) ? tiny_addr :
                          (mode_in == tcra_pkg::ADDR_SHORT) ? short_addr :
                          (mode_in == tcra_pkg::ADDR_DIRECT) ? direct_addr : full_addr;
    assign addr_out = (raw_addr_out == tcra_pkg::IDX_DATA_ADDR) ? {6'h00, index_in} : raw_addr_out;
    assign idx_ptr_sel_out = (addr_out == tcra_pkg::IDX_PTR_ADDR);
endmodule : tcra_addr_gen
`default_nettype wire

/* File: tcra_reset_ctl.sv */
// reset sequencer: source synchronising, cause recording, clock hold and debug strap
`timescale 1ns/1ps
`default_nettype none
module tcra_reset_ctl (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // pins
    input wire logic ext_reset_n_in,
    input wire logic low_voltage_in,
    input wire logic debug_entry_pin_in,
    // same-clock events
    input wire logic watchdog_in,
    input wire logic bad_opcode_in,
    input wire logic bad_addr_in,
    // to the core
    output logic core_reset_out,
    output logic release_out,
    output logic debug_entry_out,
    output var tcra_pkg::tcra_cause_t cause_out
);
    logic [2:0] pin_act;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    tcra_pkg::tcra_rstate_t state_q;
    tcra_pkg::tcra_cause_t pend_q;
    logic release_q;
    logic debug_q;
    logic [1:0] settle_q;

    // all pins active high before the first flop; debug pin low means enter
    assign pin_act = {~debug_entry_pin_in, low_voltage_in, ~ext_reset_n_in};

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    sync1_q[i] <= 1'b0;
                    sync2_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= pin_act[i];
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    logic level_src;
    logic any_event;
    assign level_src = sync2_q[0] | sync2_q[1];
    assign any_event = level_src | watchdog_in | bad_opcode_in | bad_addr_in;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= tcra_pkg::RS_RECORD;
            pend_q <= '{power_on: 1'b1, default: 1'b0};
            cause_out <= '0;
            release_q <= 1'b0;
            debug_q <= 1'b0;
            settle_q <= 2'h0;
        end else begin
            release_q <= 1'b0;
            settle_q <= {settle_q[0], 1'b1};
            unique case (state_q)
                tcra_pkg::RS_RUN: if (any_event) begin
                    state_q <= tcra_pkg::RS_RECORD;
                    pend_q <= {1'b0, sync2_q[0], sync2_q[1], watchdog_in, bad_opcode_in, bad_addr_in};
                end
                tcra_pkg::RS_RECORD: begin
                    cause_out <= pend_q;
                    state_q <= tcra_pkg::RS_HOLD;
                end
                // after a power-on the pins need two edges to reach sync2, so the strap is not read early
                tcra_pkg::RS_HOLD: if (!level_src && settle_q[1]) begin
                    state_q <= tcra_pkg::RS_RUN;
                    release_q <= 1'b1;
                    debug_q <= sync2_q[2];
                end
                default: state_q <= tcra_pkg::RS_RECORD;
            endcase
        end
    end

    assign core_reset_out = (state_q != tcra_pkg::RS_RUN);
    assign release_out = release_q;
    assign debug_entry_out = debug_q;
endmodule : tcra_reset_ctl
`default_nettype wire

/* File: tcra_mem_model.sv */
// program and data memory model with asynchronous read and no wait states
`timescale 1ns/1ps
`default_nettype none
module tcra_mem_model (
    // clock and bus
    input wire logic sys_clk_in,
    input wire logic [13:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic rd_in,
    input wire logic wr_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [0:16383];
    logic [7:0] last_q;
    // outside a read the lines show no stale byte, so a late sample is caught
    assign rdata_out = rd_in ? mem[addr_in] : ~last_q;
    initial begin
        last_q = 8'h00;
        for (int i = 0; i < 16384; i++) mem[i] = 8'h00;
    end
    always @(posedge sys_clk_in) begin
        if (wr_in) mem[addr_in] <= wdata_in;
        if (rd_in) last_q <= mem[addr_in];
    end
endmodule : tcra_mem_model
`default_nettype wire

/* File: tiny_cpu_reset_and_operand_addressing_bench.sv */
// self-checking bench of the tiny cpu core running a fixed program with seeded operands
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tiny_cpu_reset_and_operand_addressing_bench;
    logic clk = 0, arst_n = 0, ext_n = 1, lv = 0, dbg = 1, wd = 0, ia = 0, wake = 0, go = 0;
    logic rd, wr, clk_en, bkg, stop;
    logic [13:0] addr, tgt, pc;
    logic [7:0] wdata, rdata, acc, sum, rr, xp;
    logic [7:0] prog [0:10];
    logic [9:0] ex;
    logic [31:0] seed = 32'h59CA3502;
    tcra_pkg::tcra_cause_t cause;
    tcra_pkg::tcra_flags_t flags;
    int bad_count = 0, total_checks = 0;
    initial forever #5 clk = ~clk;
    tcra_core u_tcra_core (.sys_clk_in(clk), .arst_n_in(arst_n), .ext_reset_n_in(ext_n), .low_voltage_in(lv),
        .debug_entry_pin_in(dbg), .watchdog_timer_timeout_in(wd), .illegal_addr_in(ia), .wake_irq_in(wake),
        .bkg_go_in(go), .mem_addr_out(addr), .mem_wdata_out(wdata), .mem_rd_out(rd), .mem_wr_out(wr),
        .mem_rdata_in(rdata), .cpu_clk_en_out(clk_en), .stop_mode_out(stop), .bkg_active_out(bkg),
        .reset_cause_out(cause), .pc_out(pc), .flags_out(flags), .acc_out(acc), .index_pointer_out(xp));
    tcra_mem_model u_tcra_mem_model (.sys_clk_in(clk), .addr_in(addr), .wdata_in(wdata), .rd_in(rd),
        .wr_in(wr), .rdata_out(rdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // {zero, carry, acc} after shifting the sum left
    function automatic logic [9:0] shl(input logic [7:0] s);
        return {s[6:0] == 7'h00, s[7], s[6:0], 1'b0};
    endfunction : shl
    task automatic wait_rd(input logic [13:0] a);
        int n = 0;
        do begin @(negedge clk); n++; end while (!(rd === 1'b1 && addr === a) && n < 300);
        `CHK("read address", a, addr)
    endtask : wait_rd
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
    initial begin
        seed = lfsr(seed);
        // offset kept clear of the program and data bytes
        rr = {seed[31], ~seed[31], seed[29:24]};
        prog = '{8'hAB, seed[7:0], 8'h65, 8'hBB, 8'h40, 8'h48, 8'hAF, 8'hAC, 8'hBF, 8'h34, rr};
        sum = seed[7:0] + seed[15:8] + seed[23:16];
        ex = shl(sum);
        tgt = ex[8] ? 14'h010B : 14'h010B + {{6{rr[7]}}, rr};
        #1;
        for (int i = 0; i < 11; i++) u_tcra_mem_model.mem[14'h0100 + i] = prog[i];
        u_tcra_mem_model.mem[14'h3FFD] = 8'hBC;
        u_tcra_mem_model.mem[14'h3FFE] = 8'h01;
        u_tcra_mem_model.mem[14'h0005] = seed[15:8];
        u_tcra_mem_model.mem[14'h0040] = seed[23:16];
        repeat (8) @(posedge clk);
        arst_n <= 1;
        wait_rd(14'h3FFD);
        wait_rd(14'h0100);
        wait_rd(14'h0005);
        wait_rd(14'h0040);
        repeat (10) @(negedge clk);
        `CHK("clock enable", 1'b0, clk_en)
        `CHK("acc", ex[7:0], acc)
        `CHK("flags", ex[9:8], flags)
        `CHK("pc", 14'h0107, pc)
        `CHK("stop mode", 1'b0, stop)
        // wake stays up through the fetch that follows, which must not be diverted
        @(posedge clk) wake <= 1;
        repeat (2) @(posedge clk);
        wake <= 0;
        wait_rd(14'h0107);
        repeat (8) @(negedge clk);
        `CHK("background", 1'b1, bkg)
        @(posedge clk) go <= 1;
        @(posedge clk) go <= 0;
        wait_rd(14'h010A);
        wait_rd(tgt);
        wait_rd(14'h3FFD);
        `CHK("cause", 6'h02, cause)
        // second pass: copy acc into the pointer, write through the window, then stop
        u_tcra_mem_model.mem[14'h0106] = 8'hEF;
        u_tcra_mem_model.mem[14'h0107] = 8'hEE;
        u_tcra_mem_model.mem[14'h0108] = 8'hAE;
        @(posedge clk) {dbg, arst_n} <= 2'b00;
        repeat (8) @(posedge clk);
        arst_n <= 1;
        repeat (10) @(negedge clk);
        `CHK("debug entry", 1'b1, bkg)
        @(posedge clk) {dbg, go} <= 2'b11;
        @(posedge clk) go <= 0;
        wait_rd(14'h3FFD);
        repeat (30) @(negedge clk);
        `CHK("stop mode", 1'b1, stop)
        `CHK("index pointer", ex[7:0], xp)
        `CHK("window write", ex[7:0], u_tcra_mem_model.mem[ex[7:0]])
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) {ext_n, lv, wd, ia} <= {k != 0, k == 1, k == 2, k == 3};
            repeat (4) @(posedge clk);
            {ext_n, lv, wd, ia} <= 4'h8;
            wait_rd(14'h3FFD);
            `CHK("cause", k == 3 ? 6'h01 : 6'h10 >> k, cause)
        end
        wrap_up();
    end
endmodule : tiny_cpu_reset_and_operand_addressing_bench
`default_nettype wire
